// ### verilog/ipc_pkg.sv
// Constants, register map and shared helpers of the I/O pin port control.
// Assumes a single 40 MHz clock and an AXI4-Lite master on the register side.
package ipc_pkg;
   localparam int          IPC_PINS       = 8;
   localparam int          IPC_DBG_PINS   = 3;
   localparam int          IPC_LED_PINS   = 2;
   localparam int          IPC_FUNCS      = 4;
   localparam int          IPC_AW         = 8;
   // Register word indices (byte address bits 7:2)
   localparam logic [5:0]  IPC_IDX_DIR    = 6'h00;
   localparam logic [5:0]  IPC_IDX_DATA   = 6'h01;
   localparam logic [5:0]  IPC_IDX_PULL   = 6'h02;
   localparam logic [5:0]  IPC_IDX_FILT   = 6'h03;
   localparam logic [5:0]  IPC_IDX_FUNC   = 6'h04;
   localparam logic [5:0]  IPC_IDX_CLK    = 6'h05;
   localparam logic [5:0]  IPC_IDX_PROT   = 6'h06;
   localparam logic [5:0]  IPC_IDX_LED    = 6'h07;
   // Field positions
   localparam int          IPC_HI_BYTE    = 8;
   localparam int          IPC_CLK_DIV_LO = 4;
   localparam int          IPC_CLK_RUN_IN_DEBUG  = 8;
   // Reset values and codes
   localparam logic [15:0] IPC_UNLOCK_KEY = 16'h0096;
   localparam logic [7:0]  IPC_RST_BYTE   = 8'h00;
   localparam logic [1:0]  IPC_RESP_OKAY  = 2'b00;
   localparam logic [1:0]  IPC_RESP_SLV   = 2'b10;

   // Per bit: follow b once a and b agree, else hold q
   function automatic logic [IPC_PINS+IPC_DBG_PINS-1:0] ipc_agree
      (input logic [IPC_PINS+IPC_DBG_PINS-1:0] a,
       input logic [IPC_PINS+IPC_DBG_PINS-1:0] b,
       input logic [IPC_PINS+IPC_DBG_PINS-1:0] q);
      ipc_agree = (a & b) | (q & (a | b));
   endfunction
endpackage

// ### verilog/ipc_sync.sv
// Three-stage pad synchroniser; a change counts once stages two and three agree.
// Assumes asynchronous pad levels on d.
module ipc_sync
   import ipc_pkg::*;
(
   // Clock and reset
   input  wire logic                              aclk,
   input  wire logic                              aresetn,
   // Levels
   input  wire logic [IPC_PINS+IPC_DBG_PINS-1:0]  d,
   output logic      [IPC_PINS+IPC_DBG_PINS-1:0]  q
);
   logic [IPC_PINS+IPC_DBG_PINS-1:0] s1_ff;
   logic [IPC_PINS+IPC_DBG_PINS-1:0] s2_ff;
   logic [IPC_PINS+IPC_DBG_PINS-1:0] s3_ff;
   logic [IPC_PINS+IPC_DBG_PINS-1:0] q_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff  <= '0;
      end
      else
      begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= ipc_agree(s2_ff, s3_ff, q_ff);
      end
   end

   assign q = q_ff;
endmodule

// ### verilog/ipc_glitch_filter.sv
// Input glitch filter for one port group, stepped by the sample tick.
// Assumes tick is a one-cycle enable and d is already synchronised.
module ipc_glitch_filter
   import ipc_pkg::*;
(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Sample tick and data
   input  wire logic                 tick,
   input  wire logic [IPC_PINS-1:0]  d,
   output logic      [IPC_PINS-1:0]  q
);
   localparam int PAD = IPC_DBG_PINS;
   logic [IPC_PINS-1:0] smp_ff;
   logic [IPC_PINS-1:0] q_ff;
   logic [IPC_PINS+PAD-1:0] agree;

   assign agree = ipc_agree({{PAD{1'b0}}, d}, {{PAD{1'b0}}, smp_ff}, {{PAD{1'b0}}, q_ff});

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         smp_ff <= '0;
         q_ff   <= '0;
      end
      else if (tick)
      begin
         smp_ff <= d;
         q_ff   <= agree[IPC_PINS-1:0];
      end
   end

   assign q = q_ff;
endmodule

// ### verilog/ipc_top.sv
// I/O pin port control: one GPIO group, the debug group and LED drive pins.
// Assumes clock generator source ticks on aclk and an AXI4-Lite master.
// Function
// - Per pin pull-up, pull-down or none
// - Per pin glitch filter enable
// - GPIO or one of four peripherals
// - Reset leaves non-debug pins Hi-Z
// - Debug group pins 0-2 stay debug
// - Pins numbered 0 to 7 in the GPIO group, 0 to 2 in the debug group
// - Input enable low gates input off; here it gates GPIO data only, not periph_in
// - LED pins output only, no pulls
// - LED pins open drain, low or released
// - GPIO output may go high impedance
// - Filter works only with sample clock
// - 2-bit source and 4-bit divider
// - Sample interval from source and divider
// - Sleep-stop 0 keeps filter running
// - Sleep-stop 1 stops all filtering
// - Reject pulses below sampling interval
// - Debug mode stops clock unless enabled
// - Output bit drives pad, input reads
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
module ipc_top
   import ipc_pkg::*;
(
   // Clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // AXI4-Lite write
   input  wire logic [ipc_pkg::IPC_AW-1:0]    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ipc_pkg::IPC_AW-1:0]    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // Clock generator and system state
   input  wire logic [3:0]                    src_tick,
   input  wire logic                          sleep_stop_select,
   input  wire logic                          sleep_mode,
   input  wire logic                          debug_mode,
   // GPIO pads
   input  wire logic [ipc_pkg::IPC_PINS-1:0]  pad_in,
   output logic [ipc_pkg::IPC_PINS-1:0]       pad_out,
   output logic [ipc_pkg::IPC_PINS-1:0]       pad_oe,
   output logic [ipc_pkg::IPC_PINS-1:0]       pad_pull_en,
   output logic [ipc_pkg::IPC_PINS-1:0]       pad_pull_up,
   // Peripheral functions, index func*8+pin
   input  wire logic [31:0]                   periph_out,
   input  wire logic [31:0]                   periph_oe,
   output logic [ipc_pkg::IPC_PINS-1:0]       periph_in,
   // Debug group pads and debug unit
   input  wire logic [ipc_pkg::IPC_DBG_PINS-1:0] dbg_pad_in,
   output logic [ipc_pkg::IPC_DBG_PINS-1:0]   dbg_pad_out,
   output logic [ipc_pkg::IPC_DBG_PINS-1:0]   dbg_pad_oe,
   input  wire logic [ipc_pkg::IPC_DBG_PINS-1:0] dbg_unit_out,
   input  wire logic [ipc_pkg::IPC_DBG_PINS-1:0] dbg_unit_oe,
   output logic [ipc_pkg::IPC_DBG_PINS-1:0]   dbg_unit_in,
   // LED drive pads, pad low while enable high
   output logic [ipc_pkg::IPC_LED_PINS-1:0]   led_pad_oe
);
   // Pin configuration
   logic [IPC_PINS-1:0]     oen_ff;
   logic [IPC_PINS-1:0]     ien_ff;
   logic [IPC_PINS-1:0]     odat_ff;
   logic [IPC_PINS-1:0]     pen_ff;
   logic [IPC_PINS-1:0]     pup_ff;
   logic [IPC_PINS-1:0]     fen_ff;
   logic [IPC_PINS-1:0]     psel_ff;
   logic [2*IPC_PINS-1:0]   pmux_ff;
   logic [IPC_LED_PINS-1:0] led_ff;
   // Filter clock configuration
   logic [1:0]              csrc_ff;
   logic [3:0]              cdiv_ff;
   logic                    run_in_debug_ff;
   logic                    unlocked_ff;
   logic [3:0]              dcnt_ff;
   logic                    tick_ff;
   logic                    clk_run;
   // Input path
   logic [IPC_PINS+IPC_DBG_PINS-1:0] sync_q;
   logic [IPC_PINS-1:0]     filt_q;
   logic [IPC_PINS-1:0]     pin_lvl;
   logic [IPC_PINS-1:0]     in_data_ff;
   logic [IPC_PINS-1:0]     nxt_out;
   logic [IPC_PINS-1:0]     nxt_oe;
   // Bus slave
   logic                    aw_full_ff;
   logic                    w_full_ff;
   logic [5:0]              widx_ff;
   logic [31:0]             wdata_ff;
   logic [3:0]              wstrb_ff;
   logic                    wr_fire;
   logic                    nxt_aw_full;
   logic                    nxt_w_full;
   logic                    nxt_bvalid;
   logic                    nxt_rvalid;
   logic                    rd_take;
   logic [31:0]             wv;

   // Register view, also the base for byte-strobe merges
   function automatic logic [31:0] reg_view(input logic [5:0] idx);
      unique case (idx)
         IPC_IDX_DIR:  reg_view = {16'h0000, ien_ff, oen_ff};
         IPC_IDX_DATA: reg_view = {16'h0000, in_data_ff, odat_ff};
         IPC_IDX_PULL: reg_view = {16'h0000, pup_ff, pen_ff};
         IPC_IDX_FILT: reg_view = {24'h00_0000, fen_ff};
         IPC_IDX_FUNC: reg_view = {8'h00, pmux_ff, psel_ff};
         IPC_IDX_CLK:  reg_view = {23'h00_0000, run_in_debug_ff, cdiv_ff, 2'b00, csrc_ff};
         IPC_IDX_PROT: reg_view = {31'h0000_0000, unlocked_ff};
         IPC_IDX_LED:  reg_view = {30'h0000_0000, led_ff};
         default:      reg_view = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx <= IPC_IDX_LED);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int b = 0; b < 4; b++)
         merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
   endfunction

   // ---------------- AXI4-Lite slave ----------------
   assign wr_fire     = aw_full_ff && w_full_ff && !s_axi_bvalid;
   assign nxt_aw_full = (aw_full_ff || (s_axi_awvalid && s_axi_awready)) && !wr_fire;
   assign nxt_w_full  = (w_full_ff || (s_axi_wvalid && s_axi_wready)) && !wr_fire;
   assign nxt_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);
   assign rd_take     = s_axi_arvalid && s_axi_arready;
   assign nxt_rvalid  = rd_take || (s_axi_rvalid && !s_axi_rready);
   assign wv          = merge(reg_view(widx_ff), wdata_ff, wstrb_ff);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_ff    <= 1'b0;
         w_full_ff     <= 1'b0;
         widx_ff       <= '0;
         wdata_ff      <= '0;
         wstrb_ff      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= IPC_RESP_OKAY;
      end
      else
      begin
         aw_full_ff    <= nxt_aw_full;
         w_full_ff     <= nxt_w_full;
         s_axi_awready <= !nxt_aw_full;
         s_axi_wready  <= !nxt_w_full;
         s_axi_bvalid  <= nxt_bvalid;
         if (s_axi_awvalid && s_axi_awready)
            widx_ff <= s_axi_awaddr[IPC_AW-1:2];
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_fire)
            s_axi_bresp <= mapped(widx_ff) ? IPC_RESP_OKAY : IPC_RESP_SLV;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= IPC_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !nxt_rvalid;
         s_axi_rvalid  <= nxt_rvalid;
         if (rd_take)
         begin
            s_axi_rdata <= reg_view(s_axi_araddr[IPC_AW-1:2]);
            s_axi_rresp <= mapped(s_axi_araddr[IPC_AW-1:2]) ? IPC_RESP_OKAY : IPC_RESP_SLV;
         end
      end
   end

   // ---------------- Configuration registers ----------------
   // all-zero reset means Hi-Z
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         oen_ff  <= IPC_RST_BYTE;
         ien_ff  <= IPC_RST_BYTE;
         odat_ff <= IPC_RST_BYTE;
         pen_ff  <= IPC_RST_BYTE;
         pup_ff  <= IPC_RST_BYTE;
         fen_ff  <= IPC_RST_BYTE;
         psel_ff <= IPC_RST_BYTE;
         pmux_ff <= '0;
         led_ff  <= '0;
      end
      else if (wr_fire)
      begin
         unique case (widx_ff)
            IPC_IDX_DIR:
            begin
               oen_ff <= wv[IPC_PINS-1:0];
               ien_ff <= wv[IPC_HI_BYTE +: IPC_PINS];
            end
            IPC_IDX_DATA: odat_ff <= wv[IPC_PINS-1:0];
            IPC_IDX_PULL:
            begin
               pen_ff <= wv[IPC_PINS-1:0];
               pup_ff <= wv[IPC_HI_BYTE +: IPC_PINS];
            end
            IPC_IDX_FILT: fen_ff <= wv[IPC_PINS-1:0];
            IPC_IDX_FUNC:
            begin
               psel_ff <= wv[IPC_PINS-1:0];
               pmux_ff <= wv[IPC_HI_BYTE +: 2*IPC_PINS];
            end
            IPC_IDX_LED:  led_ff <= wv[IPC_LED_PINS-1:0];
            default:
            begin
            end
         endcase
      end
   end

   // Protection key and filter clock fields
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         unlocked_ff <= 1'b0;
         csrc_ff     <= 2'b00;
         cdiv_ff     <= 4'h0;
         run_in_debug_ff    <= 1'b0;
      end
      else if (wr_fire)
      begin
         if (widx_ff == IPC_IDX_PROT && wstrb_ff[1:0] == 2'b11)
            unlocked_ff <= (wdata_ff[15:0] == IPC_UNLOCK_KEY);
         if (widx_ff == IPC_IDX_CLK)
         begin
            run_in_debug_ff <= wv[IPC_CLK_RUN_IN_DEBUG];
            if (unlocked_ff)
            begin
               csrc_ff <= wv[1:0];
               cdiv_ff <= wv[IPC_CLK_DIV_LO +: 4];
            end
         end
      end
   end

   // ---------------- Filter sample clock ----------------
   // clock supply gating
   assign clk_run = !(sleep_mode && sleep_stop_select) && !(debug_mode && !run_in_debug_ff);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dcnt_ff <= 4'h0;
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= 1'b0;
         if (clk_run && src_tick[csrc_ff])
         begin
            if (dcnt_ff >= cdiv_ff)
            begin
               dcnt_ff <= 4'h0;
               tick_ff <= 1'b1;
            end
            else
               dcnt_ff <= dcnt_ff + 4'h1;
         end
      end
   end

   // ---------------- Input path ----------------
   // pads synchronised first
   ipc_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({dbg_pad_in, pad_in}),
      .q       (sync_q)
   );

   ipc_glitch_filter u_filt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick_ff),
      .d       (sync_q[IPC_PINS-1:0]),
      .q       (filt_q)
   );

   assign pin_lvl = (fen_ff & filt_q) | (~fen_ff & sync_q[IPC_PINS-1:0]);

   // ---------------- Pad drive, per pin ----------------
   // pins 0 to 7 of the group
   for (genvar i = 0; i < IPC_PINS; i++)
   begin : g_pin
      logic [4:0] fi;
      assign fi = {pmux_ff[2*i +: 2], 3'(i)};
      assign nxt_oe[i]  = psel_ff[i] ? periph_oe[fi]  : oen_ff[i];
      assign nxt_out[i] = psel_ff[i] ? periph_out[fi] : odat_ff[i];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pad_out     <= '0;
         pad_oe      <= '0;
         pad_pull_en <= '0;
         pad_pull_up <= '0;
         in_data_ff  <= '0;
         periph_in   <= '0;
      end
      else
      begin
         pad_out     <= nxt_out;
         pad_oe      <= nxt_oe;
         pad_pull_en <= pen_ff & ~nxt_oe & ~psel_ff;
         pad_pull_up <= pup_ff;
         in_data_ff  <= pin_lvl & ien_ff & ~psel_ff;
         periph_in   <= pin_lvl & psel_ff;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dbg_pad_out <= '0;
         dbg_pad_oe  <= '0;
         dbg_unit_in <= '0;
         led_pad_oe  <= '0;
      end
      else
      begin
         dbg_pad_out <= dbg_unit_out;
         dbg_pad_oe  <= dbg_unit_oe;
         dbg_unit_in <= sync_q[IPC_PINS +: IPC_DBG_PINS];
         led_pad_oe  <= led_ff;
      end
   end

   // ---------------- Assertions ----------------
   property p_reset_hiz;
      @(posedge aclk) !$past(aresetn) |-> (pad_oe == '0 && led_pad_oe == '0);
   endproperty
   a_reset_hiz: assert property (p_reset_hiz) else $error("pads driven after reset");

   property p_pull_off;
      @(posedge aclk) disable iff (!aresetn) (pad_oe & pad_pull_en) == '0;
   endproperty
   a_pull_off: assert property (p_pull_off) else $error("pull on a driven pad");

   property p_ien_gate;
      @(posedge aclk) disable iff (!aresetn) $past(ien_ff) == '0 |-> in_data_ff == '0;
   endproperty
   a_ien_gate: assert property (p_ien_gate) else $error("input seen while disabled");

   property p_locked;
      @(posedge aclk) disable iff (!aresetn)
         (wr_fire && widx_ff == IPC_IDX_CLK && !unlocked_ff) |=> $stable({csrc_ff, cdiv_ff});
   endproperty
   a_locked: assert property (p_locked) else $error("locked clock field changed");

   property p_unlock;
      @(posedge aclk) disable iff (!aresetn)
         (wr_fire && widx_ff == IPC_IDX_PROT && wstrb_ff[1:0] == 2'b11)
         |=> unlocked_ff == (wdata_ff[15:0] == IPC_UNLOCK_KEY);
   endproperty
   a_unlock: assert property (p_unlock) else $error("key decode wrong");

   property p_tick_stop;
      @(posedge aclk) disable iff (!aresetn) !clk_run |=> !tick_ff;
   endproperty
   a_tick_stop: assert property (p_tick_stop) else $error("tick while clock stopped");

   property p_filt_hold;
      @(posedge aclk) disable iff (!aresetn) !clk_run ##1 !clk_run |=> $stable(filt_q);
   endproperty
   a_filt_hold: assert property (p_filt_hold) else $error("filter moved without clock");

   property p_bhold;
      @(posedge aclk) disable iff (!aresetn)
         s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");

   property p_rhold;
      @(posedge aclk) disable iff (!aresetn)
         s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule

// ### bench/ipc_pad_model.sv
// Pad model: resolves each GPIO pad level from design drive, outside drive and pulls.
// Assumes the bench sets ext_en/ext_val in place of outside circuitry.
module ipc_pad_model
   import ipc_pkg::*;
(
   // Clock
   input  wire logic                 aclk,
   // Pad controls from the design
   input  wire logic [IPC_PINS-1:0]  pad_out,
   input  wire logic [IPC_PINS-1:0]  pad_oe,
   input  wire logic [IPC_PINS-1:0]  pad_pull_en,
   input  wire logic [IPC_PINS-1:0]  pad_pull_up,
   // Outside drivers
   input  wire logic [IPC_PINS-1:0]  ext_en,
   input  wire logic [IPC_PINS-1:0]  ext_val,
   // Resolved level
   output logic      [IPC_PINS-1:0]  pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [IPC_PINS-1:0] float_ff = 8'h00;
   // Floating pad toggles so an unknown never settles to a lucky value
   always @(posedge aclk)
      float_ff <= ~float_ff;
   // Design drive wins, then outside drive, then pull, else floating
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & pad_pull_en & pad_pull_up)
                 | (~pad_oe & ~ext_en & ~pad_pull_en & float_ff);
endmodule

// ### bench/tb.sv
// Self-checking bench of the pin port control over AXI4-Lite.
// Assumes the pad model on the GPIO pins and free-running source ticks.
module tb
   import ipc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, sleep_stop_select, sleep_mode, debug_mode;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, pad_in, pad_out, pad_oe, pad_pull_en;
   logic [7:0]  pad_pull_up, periph_in, ext_en, ext_val;
   logic [31:0] s_axi_wdata, s_axi_rdata, periph_out, periph_oe;
   logic [3:0]  s_axi_wstrb, src_tick;
   logic [1:0]  s_axi_bresp, s_axi_rresp, led_pad_oe;
   logic [2:0]  dbg_pad_in, dbg_pad_out, dbg_pad_oe, dbg_unit_out, dbg_unit_oe, dbg_unit_in;
   int          num_errors = 0;
   int          tests_run = 0;

   ipc_top ipc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_tick, .sleep_stop_select,
      .sleep_mode, .debug_mode, .pad_in, .pad_out, .pad_oe, .pad_pull_en, .pad_pull_up,
      .periph_out, .periph_oe, .periph_in, .dbg_pad_in, .dbg_pad_out, .dbg_pad_oe,
      .dbg_unit_out, .dbg_unit_oe, .dbg_unit_in, .led_pad_oe);
   ipc_pad_model ipc_pad_model_inst (.aclk, .pad_out, .pad_oe, .pad_pull_en,
      .pad_pull_up, .ext_en, .ext_val, .pad_in);

   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic stop_test;
      if (num_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Settle after the edge so registered outputs are looked at stable
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hung wait
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bvalid, 1);
      chk(s_axi_bresp, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rvalid, 1);
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask

   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {aresetn, sleep_stop_select, sleep_mode, debug_mode} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, ext_en, ext_val} = 32'h0000_0000;
      {s_axi_wdata, periph_out, periph_oe} = 96'h0;
      s_axi_wstrb = 4'hF;
      // Only source 1 ticks, so a wrong source select stalls the filter
      src_tick = 4'h2;
      dbg_unit_out = 3'h3;
      dbg_unit_oe = 3'h5;
      dbg_pad_in = 3'h6;
      cyc(5);
      aresetn <= 1'b1;
      cyc(1);
      chk(pad_oe, 0);
      chk(pad_pull_en, 0);
      chk(led_pad_oe, 0);
      chk(dbg_pad_oe, 3'h5);
      rd(8'h00, 0, IPC_RESP_OKAY);
      rd(8'h10, 0, IPC_RESP_OKAY);
      chk(dbg_unit_in, 3'h6);
      wr(8'h00, 32'h0000_00F0, IPC_RESP_OKAY);
      wr(8'h04, 32'h0000_00A5, IPC_RESP_OKAY);
      wr(8'h08, 32'h0000_05FF, IPC_RESP_OKAY);
      cyc(2);
      chk(pad_oe, 8'hF0);
      chk(pad_out & 8'hF0, 8'hA0);
      chk(pad_pull_en, 8'h0F);
      chk(pad_pull_up & 8'h0F, 8'h05);
      ext_en <= 8'hFF;
      ext_val <= 8'h5A;
      wr(8'h00, 32'h0000_FF00, IPC_RESP_OKAY);
      cyc(8);
      chk(pad_oe, 0);
      chk(pad_pull_en, 8'hFF);
      rd(8'h04, 32'h0000_5AA5, IPC_RESP_OKAY);
      wr(8'h00, 32'h0000_0F00, IPC_RESP_OKAY);
      rd(8'h04, 32'h0000_0AA5, IPC_RESP_OKAY);
      wr(8'h1C, 32'h0000_0002, IPC_RESP_OKAY);
      cyc(2);
      chk(led_pad_oe, 2'h2);
      rd(8'h1C, 32'h0000_0002, IPC_RESP_OKAY);
      wr(8'h14, 32'h0000_0021, IPC_RESP_OKAY);
      rd(8'h14, 0, IPC_RESP_OKAY);
      wr(8'h18, 32'h0000_0096, IPC_RESP_OKAY);
      rd(8'h18, 32'h0000_0001, IPC_RESP_OKAY);
      wr(8'h14, 32'h0000_0021, IPC_RESP_OKAY);
      rd(8'h14, 32'h0000_0021, IPC_RESP_OKAY);
      wr(8'h18, 32'h0000_1234, IPC_RESP_OKAY);
      rd(8'h18, 0, IPC_RESP_OKAY);
      wr(8'h14, 32'h0000_0130, IPC_RESP_OKAY);
      rd(8'h14, 32'h0000_0121, IPC_RESP_OKAY);
      rd(8'h40, 0, IPC_RESP_SLV);
      wr(8'h40, 32'h0000_FFFF, IPC_RESP_SLV);
      wr(8'h0C, 32'h0000_0001, IPC_RESP_OKAY);
      wr(8'h00, 32'h0000_0100, IPC_RESP_OKAY);
      ext_val <= 8'h00;
      cyc(40);
      // Three-cycle pulse clears the synchroniser but meets one sample only
      @(posedge aclk);
      ext_val <= 8'h01;
      repeat (3) @(posedge aclk);
      ext_val <= 8'h00;
      cyc(40);
      rd(8'h04, 32'h0000_00A5, IPC_RESP_OKAY);
      ext_val <= 8'h01;
      cyc(40);
      rd(8'h04, 32'h0000_01A5, IPC_RESP_OKAY);
      sleep_mode <= 1'b1;
      sleep_stop_select <= 1'b1;
      cyc(4);
      ext_val <= 8'h00;
      cyc(40);
      rd(8'h04, 32'h0000_01A5, IPC_RESP_OKAY);
      sleep_stop_select <= 1'b0;
      cyc(40);
      rd(8'h04, 32'h0000_00A5, IPC_RESP_OKAY);
      sleep_mode <= 1'b0;
      debug_mode <= 1'b1;
      ext_val <= 8'h01;
      cyc(40);
      rd(8'h04, 32'h0000_01A5, IPC_RESP_OKAY);
      wr(8'h14, 32'h0000_0021, IPC_RESP_OKAY);
      cyc(4);
      ext_val <= 8'h00;
      cyc(40);
      rd(8'h04, 32'h0000_01A5, IPC_RESP_OKAY);
      debug_mode <= 1'b0;
      cyc(40);
      rd(8'h04, 32'h0000_00A5, IPC_RESP_OKAY);
      wr(8'h00, 0, IPC_RESP_OKAY);
      // Only the selected function's enable is set, so a wrong mux shows
      for (int f = 0; f < 4; f++)
      begin
         periph_oe <= 32'h0000_0001 << (f * 8 + 1);
         periph_out <= 32'h0000_0001 << (f * 8 + 1);
         wr(8'h10, 32'h0000_0002 | (f << 10), IPC_RESP_OKAY);
         cyc(2);
         chk(pad_oe[1], 1);
         chk(pad_out[1], 1);
      end
      cyc(8);
      chk(periph_in[1], 1);
      chk(pad_pull_en[1], 0);
      stop_test;
   end

   initial
   begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      stop_test;
   end
endmodule
